//--- design/warmup_pkg.sv
package warmup_pkg;
   // register byte offsets
   localparam logic [3:0] OSC_CTRL_OFS = 4'h0;
   localparam logic [3:0] MODE_CTRL_OFS = 4'h4;
   // oscillator_control_register layout
   localparam int WARMUP_GO_BIT = 0;
   localparam int WARMUP_COUNT_LO_POS = 4;
   localparam int WARMUP_COUNT_LO_W = 4;
   localparam int INT_HS_EN_BIT = 8;
   localparam int EXT_HS_EN_BIT = 9;
   localparam int LS_EN_BIT = 10;
   localparam int SYSTEM_OSC_SELECT_POS = 12;
   localparam int WARMUP_SRC_SEL_B1_BIT = 16;
   localparam int WARMUP_SRC_SEL_B2_BIT = 17;
   localparam int WARMUP_COUNT_HI_POS = 20;
   localparam int WARMUP_COUNT_HI_W = 12;
   localparam int WARMUP_COUNT_W = WARMUP_COUNT_HI_W + WARMUP_COUNT_LO_W;
   localparam logic [31:0] OSC_CTRL_WMASK = 32'hfff3_37f0;
   localparam logic [31:0] OSC_CTRL_RESET = 32'h0000_0100;
   // mode control register layout
   localparam int STANDBY_SEL_POS = 0;
   localparam int SLOW_MODE_BIT = 4;
   localparam int SYSCLK_EN_STAT_BIT = 8;
   localparam int STATE_STAT_POS = 9;
   localparam int WARMUP_BUSY_STAT_BIT = 13;
   localparam logic [31:0] MODE_CTRL_WMASK = 32'h0000_0013;
   localparam logic [31:0] MODE_CTRL_RESET = 32'h0000_0000;
   // standby selection codes
   localparam logic [1:0] STANDBY_NONE = 2'h0;
   localparam logic [1:0] STANDBY_STOP = 2'h1;
   localparam logic [1:0] STANDBY_SLEEP = 2'h2;
   // warm-up source codes {b2,b1}; the external clock input has no code
   localparam logic [1:0] WSRC_INT_HS = 2'h0;
   localparam logic [1:0] WSRC_EXT_HS = 2'h1;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      ST_RUN = 4'h1,
      ST_STOP = 4'h2,
      ST_SLEEP = 4'h4,
      ST_WARM = 4'h8
   } pwr_state_t;
endpackage : warmup_pkg

//--- design/warmup_if.sv
`timescale 1ns/10ps
interface warmup_if #(parameter int COUNT_W = 16);
   logic start;
   logic [COUNT_W-1:0] target;
   logic srcLevel;
   logic busy;
   logic done;
   modport ctrl (output start, output target, output srcLevel, input busy, input done);
   modport timer (input start, input target, input srcLevel, output busy, output done);
endinterface : warmup_if

//--- design/warmup_timer.sv
`timescale 1ns/10ps
module warmup_timer #(
   parameter int COUNT_W = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // control side
   warmup_if.timer wu
);
   // the compare and the increment are only sized for these widths
   if (COUNT_W < 2 || COUNT_W > 31) begin : g_bad_width
      $error("warmup_timer: COUNT_W out of range");
   end

   typedef struct packed {
      logic busy;
      logic done;
      logic prevLevel;
      logic [COUNT_W-1:0] cnt;
   } tmr_t;

   tmr_t st_r;
   tmr_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      st_nxt.prevLevel = wu.srcLevel;
      if (wu.start && !st_r.busy) begin
         st_nxt.busy = 1'b1;
         st_nxt.cnt = '0;
      end else if (st_r.busy) begin
         if (st_r.cnt >= wu.target) begin
            st_nxt.busy = 1'b0;
            st_nxt.done = 1'b1;
         end else if (wu.srcLevel && !st_r.prevLevel) begin
            st_nxt.cnt = st_r.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign wu.busy = st_r.busy;
   assign wu.done = st_r.done;
endmodule : warmup_timer

//--- design/low_power_warmup_control.sv
// Behaviour
// - wake from stop/sleep runs warm-up, then clock
// - external clock input never counts warm-up
// - reset return gives no warm-up
// - slow-stop-slow warms up automatically
// - slow-sleep-slow keeps low-speed running, no warm-up
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps
module low_power_warmup_control (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // axi4-lite write address
   input wire logic [3:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   // axi4-lite write data
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // axi4-lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read
   input wire logic [3:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // oscillator pins, asynchronous
   input wire logic intHsOscPin,
   input wire logic extHsOscPin,
   input wire logic lsOscPin,
   // core standby handshake
   input wire logic standbyEnter,
   input wire logic wakeRequest,
   // clock tree controls
   output logic sysClkEnable,
   output logic intHsOscEnable,
   output logic extHsOscEnable,
   output logic lsOscEnable
);
   localparam int CW = warmup_pkg::WARMUP_COUNT_W;

   typedef struct packed {
      warmup_pkg::pwr_state_t state;
      logic [31:0] oscCtl;
      logic [31:0] modeCtl;
      logic [2:0] syncA;
      logic [2:0] syncB;
      logic wuStart;
      logic awHeld;
      logic [3:0] awAddr;
      logic wHeld;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic sysClkEn;
      logic intHsEn;
      logic extHsEn;
      logic lsEn;
   } ctl_t;

   localparam ctl_t CTL_RESET = '{
      state: warmup_pkg::ST_RUN, oscCtl: warmup_pkg::OSC_CTRL_RESET,
      modeCtl: warmup_pkg::MODE_CTRL_RESET, syncA: 3'h0, syncB: 3'h0, wuStart: 1'b0,
      awHeld: 1'b0, awAddr: 4'h0, wHeld: 1'b0, wData: 32'h0000_0000, wStrb: 4'h0,
      awready: 1'b1, wready: 1'b1, bvalid: 1'b0, bresp: warmup_pkg::RESP_OKAY,
      arready: 1'b1, rvalid: 1'b0, rdata: 32'h0000_0000, rresp: warmup_pkg::RESP_OKAY,
      sysClkEn: 1'b1, intHsEn: 1'b1, extHsEn: 1'b0, lsEn: 1'b0};

   ctl_t c_r;
   ctl_t c_nxt;

   warmup_if #(.COUNT_W(CW)) wu ();

   warmup_timer #(.COUNT_W(CW)) u_timer (
      .clk(clk),
      .srst(srst),
      .wu(wu)
   );

   function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
                                               input logic [3:0] strb, input logic [31:0] mask);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return res & mask;
   endfunction : merge_bytes

   // reads the synchronised source; the external clock input is not even wired here
   always_comb begin
      unique case ({c_r.oscCtl[warmup_pkg::WARMUP_SRC_SEL_B2_BIT],
                    c_r.oscCtl[warmup_pkg::WARMUP_SRC_SEL_B1_BIT]})
         warmup_pkg::WSRC_INT_HS: wu.srcLevel = c_r.syncB[0];
         warmup_pkg::WSRC_EXT_HS: wu.srcLevel = c_r.syncB[1];
         default: wu.srcLevel = c_r.syncB[2];
      endcase
   end

   assign wu.target = {c_r.oscCtl[warmup_pkg::WARMUP_COUNT_HI_POS +: warmup_pkg::WARMUP_COUNT_HI_W],
                       c_r.oscCtl[warmup_pkg::WARMUP_COUNT_LO_POS +: warmup_pkg::WARMUP_COUNT_LO_W]};
   assign wu.start = c_r.wuStart;

   always_comb begin
      logic swGo;
      logic [1:0] stbySel;
      logic slow;
      swGo = 1'b0;
      stbySel = c_r.modeCtl[warmup_pkg::STANDBY_SEL_POS +: 2];
      slow = c_r.modeCtl[warmup_pkg::SLOW_MODE_BIT];
      c_nxt = c_r;
      c_nxt.syncA = {lsOscPin, extHsOscPin, intHsOscPin};
      c_nxt.syncB = c_r.syncA;
      c_nxt.wuStart = 1'b0;

      // write channel: address and data taken in either order
      if (awvalid && c_r.awready) begin
         c_nxt.awHeld = 1'b1;
         c_nxt.awAddr = awaddr;
      end
      if (wvalid && c_r.wready) begin
         c_nxt.wHeld = 1'b1;
         c_nxt.wData = wdata;
         c_nxt.wStrb = wstrb;
      end
      if (c_r.awHeld && c_r.wHeld && !c_r.bvalid) begin
         c_nxt.awHeld = 1'b0;
         c_nxt.wHeld = 1'b0;
         c_nxt.bvalid = 1'b1;
         c_nxt.bresp = warmup_pkg::RESP_OKAY;
         unique case (c_r.awAddr)
            warmup_pkg::OSC_CTRL_OFS: begin
               c_nxt.oscCtl = merge_bytes(c_r.oscCtl, c_r.wData, c_r.wStrb, warmup_pkg::OSC_CTRL_WMASK);
               swGo = c_r.wStrb[0] && c_r.wData[warmup_pkg::WARMUP_GO_BIT];
            end
            warmup_pkg::MODE_CTRL_OFS: begin
               c_nxt.modeCtl = merge_bytes(c_r.modeCtl, c_r.wData, c_r.wStrb, warmup_pkg::MODE_CTRL_WMASK);
            end
            default: c_nxt.bresp = warmup_pkg::RESP_SLVERR;
         endcase
      end
      if (c_r.bvalid && bready) begin
         c_nxt.bvalid = 1'b0;
      end
      // ready is registered from the next-state values, so it drops at the handshake edge; the held flag keeps a second beat out
      c_nxt.awready = !c_nxt.awHeld && !c_nxt.bvalid && !(awvalid && c_r.awready);
      c_nxt.wready = !c_nxt.wHeld && !c_nxt.bvalid && !(wvalid && c_r.wready);

      // read channel
      if (arvalid && c_r.arready) begin
         c_nxt.arready = 1'b0;
         c_nxt.rvalid = 1'b1;
         c_nxt.rresp = warmup_pkg::RESP_OKAY;
         unique case (araddr)
            warmup_pkg::OSC_CTRL_OFS: begin
               c_nxt.rdata = c_r.oscCtl;
               c_nxt.rdata[warmup_pkg::WARMUP_GO_BIT] = wu.busy;
            end
            warmup_pkg::MODE_CTRL_OFS: begin
               c_nxt.rdata = c_r.modeCtl;
               c_nxt.rdata[warmup_pkg::SYSCLK_EN_STAT_BIT] = c_r.sysClkEn;
               c_nxt.rdata[warmup_pkg::STATE_STAT_POS +: 4] = c_r.state;
               c_nxt.rdata[warmup_pkg::WARMUP_BUSY_STAT_BIT] = wu.busy;
            end
            default: begin
               c_nxt.rdata = 32'h0000_0000;
               c_nxt.rresp = warmup_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (c_r.rvalid && rready) begin
         c_nxt.rvalid = 1'b0;
         c_nxt.arready = 1'b1;
      end

      // power mode sequencing
      unique case (c_r.state)
         warmup_pkg::ST_RUN: begin
            // entry is ignored while a warm-up is counting
            if (standbyEnter && !wu.busy && stbySel == warmup_pkg::STANDBY_STOP) begin
               c_nxt.state = warmup_pkg::ST_STOP;
               c_nxt.sysClkEn = 1'b0;
            end else if (standbyEnter && !wu.busy && stbySel == warmup_pkg::STANDBY_SLEEP) begin
               c_nxt.state = warmup_pkg::ST_SLEEP;
               c_nxt.sysClkEn = 1'b0;
            end else if (swGo) begin
               c_nxt.wuStart = 1'b1; // software warm-up keeps the clock running
            end
         end
         warmup_pkg::ST_STOP: begin
            if (wakeRequest) begin
               c_nxt.state = warmup_pkg::ST_WARM;
               c_nxt.wuStart = 1'b1;
            end
         end
         warmup_pkg::ST_SLEEP: begin
            if (wakeRequest && slow) begin
               c_nxt.state = warmup_pkg::ST_RUN;
               c_nxt.sysClkEn = 1'b1;
            end else if (wakeRequest) begin
               c_nxt.state = warmup_pkg::ST_WARM;
               c_nxt.wuStart = 1'b1;
            end
         end
         warmup_pkg::ST_WARM: begin
            if (wu.done) begin
               c_nxt.state = warmup_pkg::ST_RUN;
               c_nxt.sysClkEn = 1'b1;
            end
         end
         default: begin
            c_nxt.state = warmup_pkg::ST_RUN;
            c_nxt.sysClkEn = 1'b1;
         end
      endcase

      // oscillators: all off in stop, low-speed kept in sleep
      c_nxt.intHsEn = c_nxt.oscCtl[warmup_pkg::INT_HS_EN_BIT] &&
                      (c_nxt.state == warmup_pkg::ST_RUN || c_nxt.state == warmup_pkg::ST_WARM);
      c_nxt.extHsEn = c_nxt.oscCtl[warmup_pkg::EXT_HS_EN_BIT] &&
                      (c_nxt.state == warmup_pkg::ST_RUN || c_nxt.state == warmup_pkg::ST_WARM);
      c_nxt.lsEn = c_nxt.oscCtl[warmup_pkg::LS_EN_BIT] && c_nxt.state != warmup_pkg::ST_STOP;
   end

   // reset lands in run with the clock on and no warm-up
   always_ff @(posedge clk) begin
      if (srst) begin
         c_r <= CTL_RESET;
      end else begin
         c_r <= c_nxt;
      end
   end

   assign awready = c_r.awready;
   assign wready = c_r.wready;
   assign bvalid = c_r.bvalid;
   assign bresp = c_r.bresp;
   assign arready = c_r.arready;
   assign rvalid = c_r.rvalid;
   assign rdata = c_r.rdata;
   assign rresp = c_r.rresp;
   assign sysClkEnable = c_r.sysClkEn;
   assign intHsOscEnable = c_r.intHsEn;
   assign extHsOscEnable = c_r.extHsEn;
   assign lsOscEnable = c_r.lsEn;
endmodule : low_power_warmup_control

//--- tb/warmup_monitor.sv
`timescale 1ns/10ps
module warmup_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // watched pins
   input wire logic standbyEnter,
   input wire logic wakeRequest,
   input wire logic sysClkEnable,
   input wire logic intHsOscEnable,
   input wire logic extHsOscEnable,
   input wire logic lsOscEnable
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // internal high-speed and low-speed oscillators parked: only a warm-up can bring the clock back
   sequence s_parked_wake;
      !sysClkEnable && !intHsOscEnable && !lsOscEnable && $rose(wakeRequest);
   endsequence
   clk_off_cause_a: assert property ($fell(sysClkEnable) |-> $past(standbyEnter))
      else $error("clock gated without standby");
   hs_off_standby_a: assert property (!sysClkEnable && !wakeRequest
      |-> !intHsOscEnable && !extHsOscEnable)
      else $error("high-speed oscillator on in standby");
   warm_hold_a: assert property (s_parked_wake |=> !sysClkEnable [*2])
      else $error("clock back before warm-up");
   wake_bound_a: assert property (!sysClkEnable && $rose(wakeRequest) |-> ##[1:400] sysClkEnable)
      else $error("clock not back after wake");
   reset_no_warm_a: assert property ($fell(srst) |-> sysClkEnable ##1 sysClkEnable)
      else $error("warm-up after reset");
   clk_on_cause_a: assert property ($rose(sysClkEnable) |-> $past(wakeRequest))
      else $error("clock back without wake");
endmodule : warmup_monitor
bind low_power_warmup_control warmup_monitor mon (.clk, .srst, .standbyEnter, .wakeRequest, .sysClkEnable,
   .intHsOscEnable, .extHsOscEnable, .lsOscEnable);

//--- tb/testbench.sv
`timescale 1ns/10ps
module testbench;
   localparam logic [3:0] OSC = warmup_pkg::OSC_CTRL_OFS;
   localparam logic [3:0] MODE = warmup_pkg::MODE_CTRL_OFS;
   logic clk = 1'b0, srst = 1'b1;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0, s;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata, d, ex, ctl, v;
   logic awready, wready, bvalid, arready, rvalid, sysClkEnable, intHsOscEnable, extHsOscEnable, lsOscEnable;
   logic [1:0] bresp, rresp, r;
   logic intHsOscPin = 1'b0, extHsOscPin = 1'b0, lsOscPin = 1'b0, standbyEnter = 1'b0, wakeRequest = 1'b0;
   int n_errors = 0, n_tests = 0, cyc, t, k;
   always #10 clk = ~clk;
   // oscillators run only while enabled and sit low otherwise, so a stale edge cannot count
   always @(posedge clk) begin
      intHsOscPin <= intHsOscEnable & ~intHsOscPin;
      extHsOscPin <= extHsOscEnable & ~extHsOscPin;
      lsOscPin <= lsOscEnable & ~lsOscPin;
   end
   low_power_warmup_control dut (.clk, .srst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .intHsOscPin,
      .extHsOscPin, .lsOscPin, .standbyEnter, .wakeRequest, .sysClkEnable, .intHsOscEnable, .extHsOscEnable,
      .lsOscEnable);
   task end_of_test;
      if (n_errors == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_of_test
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [3:0] a, input logic [31:0] val, input logic [3:0] st);
      int i;
      @(posedge clk);
      awaddr <= a;
      wdata <= val;
      wstrb <= st;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 50 && (i == 0 || bready); i++) begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            r = bresp;
            bready <= 1'b0;
         end
      end
      if (i >= 50) begin
         n_errors++;
         end_of_test;
      end
   endtask : wr
   task rd(input logic [3:0] a);
      int i;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 50 && (i == 0 || rready); i++) begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
         end
      end
      if (i >= 50) begin
         n_errors++;
         end_of_test;
      end
   endtask : rd
   function automatic logic [31:0] mk(input logic [15:0] tg, input logic [1:0] src);
      mk = {tg[15:4], 2'b00, src, 5'h0, src[1], src == 2'h1, 1'b1, tg[3:0], 4'h0};
   endfunction : mk
   function automatic logic [31:0] run_mode(input logic [31:0] m);
      run_mode = (m & warmup_pkg::MODE_CTRL_WMASK) | (32'h1 << warmup_pkg::SYSCLK_EN_STAT_BIT)
         | (32'(warmup_pkg::ST_RUN) << warmup_pkg::STATE_STAT_POS);
   endfunction : run_mode
   // cyc counts edges from wake until the clock is back
   task nap(input logic [31:0] m);
      wr(MODE, m, 4'hf);
      @(posedge clk);
      standbyEnter <= 1'b1;
      @(posedge clk);
      standbyEnter <= 1'b0;
      repeat (4) @(posedge clk);
      chk({28'h0, sysClkEnable, intHsOscEnable, extHsOscEnable, lsOscEnable}, {31'h0, m[1] & ctl[10]});
      wakeRequest <= 1'b1;
      for (cyc = 0; cyc < 600 && !sysClkEnable; cyc++)
         @(posedge clk);
      wakeRequest <= 1'b0;
      if (cyc >= 600) begin
         n_errors++;
         end_of_test;
      end
   endtask : nap
   initial begin
      void'($urandom(32'heab78daa));
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      rd(OSC);
      chk(d, warmup_pkg::OSC_CTRL_RESET);
      rd(MODE);
      chk(d, run_mode(warmup_pkg::MODE_CTRL_RESET));
      ex = warmup_pkg::OSC_CTRL_RESET;
      for (k = 0; k < 6; k++) begin
         v = $urandom & 32'hffff_fffe;
         s = 4'($urandom);
         wr(OSC, v, s);
         chk({30'h0, r}, {30'h0, warmup_pkg::RESP_OKAY});
         ex = (ex & ~({{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & warmup_pkg::OSC_CTRL_WMASK))
            | (v & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & warmup_pkg::OSC_CTRL_WMASK);
         rd(OSC);
         chk(d, ex);
         chk({30'h0, r}, {30'h0, warmup_pkg::RESP_OKAY});
      end
      wr(4'h8, $urandom, 4'hf);
      chk({30'h0, r}, {30'h0, warmup_pkg::RESP_SLVERR});
      rd(4'hc);
      chk({r, d[29:0]}, {warmup_pkg::RESP_SLVERR, 30'h0});
      // every source code, stop then sleep, with a random count
      for (k = 0; k < 8; k++) begin
         t = 1 + $urandom % 40;
         ctl = mk(t[15:0], k[1:0]);
         wr(OSC, ctl, 4'hf);
         nap(k < 4 ? {30'h0, warmup_pkg::STANDBY_STOP} : {30'h0, warmup_pkg::STANDBY_SLEEP});
         chk(32'(cyc >= 2 * t && cyc <= 2 * t + 24), 32'h1);
         chk({28'h0, sysClkEnable, intHsOscEnable, extHsOscEnable, lsOscEnable}, {28'h0, 2'b11, k[1:0] == 2'h1, k[1]});
         rd(MODE);
         chk(d, run_mode(k < 4 ? 32'h1 : 32'h2));
      end
      ctl = mk(16'h8, 2'h2);
      wr(OSC, ctl | 32'h1, 4'hf);
      for (k = 0; k < 40; k++) begin
         rd(OSC);
         if (d[0] === 1'b0) break;
      end
      chk({30'h0, d[0], sysClkEnable}, 32'h1);
      nap(32'h12);
      chk(32'(cyc <= 3), 32'h1);
      nap(32'h11);
      chk(32'(cyc >= 16 && cyc <= 40), 32'h1);
      // back to normal: high-speed warm-up first
      wr(OSC, mk(16'h8, 2'h0) | 32'h1, 4'hf);
      for (k = 0; k < 40; k++) begin
         rd(OSC);
         if (d[0] === 1'b0) break;
      end
      chk({30'h0, d[0], sysClkEnable}, 32'h1);
      // 5000 edges of the bench's 25 MHz oscillator make 200us; reset must skip them all
      wr(OSC, mk(16'h1388, 2'h0), 4'hf);
      // reset while stopped must hand back a running clock at once
      wr(MODE, 32'h1, 4'hf);
      @(posedge clk);
      standbyEnter <= 1'b1;
      @(posedge clk);
      standbyEnter <= 1'b0;
      srst <= 1'b1;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk({28'h0, sysClkEnable, intHsOscEnable, extHsOscEnable, lsOscEnable}, 32'hc);
      rd(MODE);
      chk(d, run_mode(32'h0));
      end_of_test;
   end
endmodule : testbench
